/* File: rtl/motor_restart_inhibit.sv */
// Motor restart inhibition: start detection, starts-per-hour window, minimum interval
//
// Behaviour
// - Start seen when current, first below 10 % nominal, exceeds start threshold.
// - After a start, current below 10 % nominal means motor stopped.
// - Alarm from second-to-last permitted start until max reached or hour passes.
// - Inhibit for minimum time between starts after every start.
// - Inhibit while start count equals maximum, until an hour has passed.
// - Maximum starts per hour accepts 1 to 20.
// - Minimum time between starts 0 to 100 min in 0.1 min steps.
// - Minimum time of zero disables the interval inhibit.
// - Default elapsed 120 min permits start right after power-up.
// - Default elapsed 0 min inhibits after power-up for minimum time.
// - Only one set of settings exists.
`timescale 1ns/100ps
module motor_restart_inhibit
	import restart_inhibit_pkg::*;
#(
	parameter int TICK_CYC   = TICK_CYCLES,
	parameter int MAX_SLOTS  = 20
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire meas_type    meas,
	input  wire setting_type settings,
	output logic             start_alarm,
	output logic             start_inhibit,
	output logic             motor_running_flag,
	output logic [STARTS_W-1:0] start_count
);

	////////////////////////////////////////////////////////////////////////
	localparam int PRE_W = $clog2(TICK_CYC + 1);
	localparam int AGE_W = 10;

	typedef struct packed {
		motor_state_type              mstate;
		logic                         was_low;
		logic [PRE_W-1:0]             prescale;
		logic [ELAPSED_W-1:0]         elapsed;
		logic [MAX_SLOTS-1:0]         slot_used;
		logic [MAX_SLOTS-1:0][AGE_W-1:0] slot_age;
		logic [STARTS_W-1:0]          count;
		logic                         alarm;
		logic                         inhibit;
		logic                         boot;
		logic                         running;
	} state_type;

	state_type state_r, state_nxt;

	// Single settings set, clamped into its legal range
	logic [STARTS_W-1:0] max_eff;
	logic [MINT_W-1:0]   min_eff;
	logic                tick;
	logic                start_evt;
	logic                low_cur;
	logic [STARTS_W-1:0] cnt_v;
	logic                placed;

	always_comb begin
		max_eff = settings.max_starts;
		if (max_eff < STARTS_MIN) max_eff = STARTS_MIN;
		if (max_eff > STARTS_MAX) max_eff = STARTS_MAX;
		min_eff = (settings.min_time_between > MINT_MAX) ? MINT_MAX : settings.min_time_between;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		cnt_v     = '0;
		placed    = 1'b0;
		low_cur   = meas.current < meas.tenth_nominal;
		tick      = (state_r.prescale == PRE_W'(TICK_CYC - 1));
		start_evt = 1'b0;
		state_nxt.prescale = tick ? '0 : state_r.prescale + 1'b1;
		state_nxt.boot = 1'b0;
		// Elapsed timer counts tenth-minute ticks and saturates at 120 min
		if (state_r.boot) begin
			// Preload elapsed-time timer from default setting
			state_nxt.elapsed = settings.def_elapsed_120 ? ELAPSED_W'(DEF_ELAPSED_120_TICKS) : ELAPSED_RST;
		end else if (tick && state_r.elapsed != ELAPSED_W'(DEF_ELAPSED_120_TICKS)) begin
			state_nxt.elapsed = state_r.elapsed + 1'b1;
		end
		case (state_r.mstate)
			motor_stopped: begin
				if (low_cur) state_nxt.was_low = 1'b1;
				if (state_r.was_low && meas.current > meas.motor_start_detect_threshold) begin
					start_evt = 1'b1;
					state_nxt.mstate  = motor_running;
					state_nxt.was_low = 1'b0;
				end
			end
			motor_running: begin
				if (low_cur) begin
					state_nxt.mstate  = motor_stopped;
					state_nxt.was_low = 1'b1;
				end
			end
			default: state_nxt.mstate = motor_stopped;
		endcase
		state_nxt.running = (state_nxt.mstate == motor_running);
		// Age the recorded starts; drop those older than one hour
		for (int i = 0; i < MAX_SLOTS; i++) begin
			if (state_r.slot_used[i] && tick) begin
				if (state_r.slot_age[i] == AGE_W'(HOUR_TICKS - 1)) state_nxt.slot_used[i] = 1'b0;
				else state_nxt.slot_age[i] = state_r.slot_age[i] + 1'b1;
			end
		end
		// A start seen in the boot cycle moves the motor state but is not recorded
		if (start_evt && !state_r.boot) begin
			state_nxt.elapsed = '0;
			for (int i = 0; i < MAX_SLOTS; i++) begin
				if (!placed && !state_nxt.slot_used[i]) begin
					state_nxt.slot_used[i] = 1'b1;
					state_nxt.slot_age[i]  = '0;
					placed = 1'b1;
				end
			end
		end
		for (int i = 0; i < MAX_SLOTS; i++) cnt_v = cnt_v + STARTS_W'(state_nxt.slot_used[i]);
		state_nxt.count = cnt_v;
		// Alarm from max-1 starts up to, not including, max
		state_nxt.alarm = (cnt_v + 1'b1 == max_eff);
		// Interval inhibit and hourly limit inhibit
		state_nxt.inhibit = (cnt_v >= max_eff)
			|| (min_eff != '0 && ELAPSED_W'(min_eff) > state_nxt.elapsed);
		if (state_r.boot) state_nxt.inhibit = !settings.def_elapsed_120 && min_eff != '0;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r           <= '0;
			state_r.mstate    <= motor_stopped;
			state_r.boot      <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign start_alarm        = state_r.alarm;
	assign start_inhibit      = state_r.inhibit;
	assign motor_running_flag = state_r.running;
	assign start_count        = state_r.count;

	////////////////////////////////////////////////////////////////////////
	// Start and stop detection
	sequence low_then_high;
		state_r.mstate == motor_stopped && state_r.was_low && meas.current > meas.motor_start_detect_threshold;
	endsequence

	sequence stopped_unarmed;
		state_r.mstate == motor_stopped && !state_r.was_low;
	endsequence

	chk_start_detect: assert property (@(posedge clock) disable iff (rst)
		low_then_high ##1 1'b1 |-> state_r.mstate == motor_running)
		else $error("start not recognised");
	chk_no_arm_start: assert property (@(posedge clock) disable iff (rst)
		stopped_unarmed |=> state_r.mstate == motor_stopped)
		else $error("start without a low current first");
	chk_stop_detect: assert property (@(posedge clock) disable iff (rst)
		state_r.mstate == motor_running && meas.current < meas.tenth_nominal |=> state_r.mstate == motor_stopped)
		else $error("stop not recognised");
	chk_running_flag: assert property (@(posedge clock) disable iff (rst)
		motor_running_flag == (state_r.mstate == motor_running))
		else $error("running output disagrees with motor state");

	////////////////////////////////////////////////////////////////////////
	// Alarm and hourly limit, judged against the settings of the cycle before; the starts setting range is checked in the same cycle
	chk_alarm_level: assert property (@(posedge clock) disable iff (rst)
		start_alarm |-> start_count + 1'b1 == $past(max_eff))
		else $error("alarm outside second-to-last window");
	chk_alarm_set: assert property (@(posedge clock) disable iff (rst)
		!state_r.boot && start_count + 1'b1 == $past(max_eff) |-> start_alarm)
		else $error("alarm missing at second-to-last start");
	chk_max_inhibit: assert property (@(posedge clock) disable iff (rst)
		start_count >= $past(max_eff) |-> start_inhibit)
		else $error("max reached without inhibit");
	chk_count_range: assert property (@(posedge clock) disable iff (rst)
		max_eff >= STARTS_MIN && max_eff <= STARTS_MAX && start_count <= MAX_SLOTS)
		else $error("starts setting out of range");

	////////////////////////////////////////////////////////////////////////
	// Interval timer and power-up preload
	sequence timer_step;
		tick && !state_r.boot && !start_evt && state_r.elapsed < ELAPSED_W'(DEF_ELAPSED_120_TICKS);
	endsequence

	chk_interval_inhibit: assert property (@(posedge clock) disable iff (rst || state_r.boot)
		(low_then_high and (min_eff != '0)) |=> start_inhibit)
		else $error("no inhibit after start");
	chk_interval_release: assert property (@(posedge clock) disable iff (rst)
		!state_r.boot && $past(min_eff) != '0 && start_count < $past(max_eff)
		&& state_r.elapsed >= ELAPSED_W'($past(min_eff)) |-> !start_inhibit)
		else $error("inhibit held after interval expired");
	chk_zero_disable: assert property (@(posedge clock) disable iff (rst)
		$past(min_eff) == '0 && start_count < $past(max_eff) && !$past(state_r.boot) |-> !start_inhibit)
		else $error("inhibit with interval disabled");
	chk_elapsed_step: assert property (@(posedge clock) disable iff (rst)
		timer_step |=> state_r.elapsed == $past(state_r.elapsed) + 1'b1)
		else $error("elapsed timer missed a tenth-minute step");
	chk_boot_preload: assert property (@(posedge clock) disable iff (rst)
		state_r.boot |=> state_r.elapsed ==
		($past(settings.def_elapsed_120) ? ELAPSED_W'(DEF_ELAPSED_120_TICKS) : ELAPSED_RST))
		else $error("elapsed timer not preloaded at power-up");
	chk_boot_permit: assert property (@(posedge clock) disable iff (rst)
		state_r.boot && settings.def_elapsed_120 |=> !start_inhibit)
		else $error("inhibit after power-up with 120 min");
	chk_boot_hold: assert property (@(posedge clock) disable iff (rst)
		state_r.boot && !settings.def_elapsed_120 && min_eff != '0 |=> start_inhibit)
		else $error("no inhibit after power-up with 0 min");

	////////////////////////////////////////////////////////////////////////
	// Record of start times
	sequence slot0_at_hour;
		tick && state_r.slot_used[0] && state_r.slot_age[0] == AGE_W'(HOUR_TICKS - 1);
	endsequence

	chk_slot_expire: assert property (@(posedge clock) disable iff (rst)
		slot0_at_hour |=> !state_r.slot_used[0] || state_r.slot_age[0] == '0)
		else $error("start older than one hour still counted");
	chk_count_match: assert property (@(posedge clock) disable iff (rst)
		start_count == STARTS_W'($countones(state_r.slot_used)))
		else $error("start count disagrees with recorded starts");

endmodule : motor_restart_inhibit

/* File: common/restart_inhibit_pkg.sv */
// Package for the motor restart inhibition stage
package restart_inhibit_pkg;
	localparam int CUR_W          = 16;
	localparam int STARTS_W       = 5;
	localparam int MINT_W         = 10;
	localparam int CLOCK_HZ       = 10_000_000;
	// One timebase tick is 0.1 min
	localparam int TICK_TENTH_MIN_S = 6;
	localparam int TICK_CYCLES    = TICK_TENTH_MIN_S * CLOCK_HZ;
	localparam int HOUR_TICKS     = 600;
	localparam int DEF_ELAPSED_120_TICKS = 1200;
	localparam int ELAPSED_W      = 11;
	localparam logic [STARTS_W-1:0] STARTS_MIN = 5'h01;
	localparam logic [STARTS_W-1:0] STARTS_MAX = 5'h14;
	localparam logic [MINT_W-1:0]   MINT_MAX   = 10'h3E8;
	localparam logic [ELAPSED_W-1:0] ELAPSED_RST = 11'h000;

	typedef enum {motor_stopped, motor_running} motor_state_type;

	typedef struct packed {
		logic [CUR_W-1:0] current;
		logic [CUR_W-1:0] tenth_nominal;
		logic [CUR_W-1:0] motor_start_detect_threshold;
	} meas_type;

	typedef struct packed {
		logic [STARTS_W-1:0] max_starts;
		logic [MINT_W-1:0]   min_time_between;
		logic                def_elapsed_120;
	} setting_type;
endpackage : restart_inhibit_pkg

/* File: verification/motor_current_model.sv */
// Motor current source feeding the stage
`timescale 1ns/100ps
module motor_current_model
	import restart_inhibit_pkg::*;
(
	input  wire logic [1:0] level,
	output meas_type        meas
);
	// 0 stopped, 1 running below start threshold, 2 start surge
	always_comb begin
		meas.tenth_nominal                = 16'h0064;
		meas.motor_start_detect_threshold = 16'h0300;
		case (level)
			2'h0:    meas.current = 16'h0010;
			2'h1:    meas.current = 16'h0200;
			default: meas.current = 16'h0400;
		endcase
	end
endmodule : motor_current_model

/* File: verification/tb_motor_restart_inhibit.sv */
// Bench for the motor restart inhibition stage
`timescale 1ns/100ps
module tb_motor_restart_inhibit;
	import restart_inhibit_pkg::*;
	logic               clock = 1'b0;
	logic               rst   = 1'b1;
	logic [1:0]         lvl   = 2'h0;
	meas_type           meas;
	setting_type        settings = '{5'h02, 10'h003, 1'b0};
	logic               alarm;
	logic               inh;
	logic               run;
	logic [STARTS_W-1:0] cnt;
	int                 bad_count  = 0;
	int                 num_checks = 0;
	always #50 clock = ~clock;
	motor_current_model cur_u (.level(lvl), .meas(meas));
	motor_restart_inhibit #(.TICK_CYC(2), .MAX_SLOTS(20)) dut_u (.clock(clock), .rst(rst), .meas(meas),
		.settings(settings), .start_alarm(alarm), .start_inhibit(inh), .motor_running_flag(run), .start_count(cnt));
	////////////////////////////////////////
	task give_verdict;
		$display("checks=%0d errors=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task wait_inh(input logic v, input int bound);
		for (int i = 0; i < bound && inh !== v; i++) cyc(1);
		chk(inh, v);
		if (inh !== v) give_verdict();
	endtask : wait_inh
	task do_reset(input logic def);
		settings.def_elapsed_120 = def;
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(2);
	endtask : do_reset
	task start_motor;
		lvl = 2'h0;
		cyc(1);
		lvl = 2'h2;
		cyc(2);
	endtask : start_motor
	////////////////////////////////////////
	task boot_cases;
		do_reset(1'b0);
		chk(inh, 1'b1);
		cyc(3);
		chk(inh, 1'b1);
		wait_inh(1'b0, 12);
		do_reset(1'b1);
		chk(inh, 1'b0);
	endtask : boot_cases
	task rise_without_stop;
		lvl = 2'h1;
		do_reset(1'b1);
		cyc(2);
		lvl = 2'h2;
		cyc(3);
		chk(run, 1'b0);
		chk(cnt, 5'h00);
	endtask : rise_without_stop
	task start_interval;
		start_motor();
		chk(run, 1'b1);
		chk(cnt, 5'h01);
		chk(inh, 1'b1);
		chk(alarm, 1'b1);
		lvl = 2'h0;
		cyc(2);
		chk(run, 1'b0);
		wait_inh(1'b0, 12);
	endtask : start_interval
	task cap_hour;
		settings.min_time_between = 10'h000;
		start_motor();
		chk(cnt, 5'h02);
		chk(alarm, 1'b0);
		chk(inh, 1'b1);
		cyc(1100);
		chk(inh, 1'b1);
		wait_inh(1'b0, 300);
		chk(cnt, 5'h01);
	endtask : cap_hour
	task zero_interval;
		do_reset(1'b1);
		start_motor();
		chk(cnt, 5'h01);
		chk(inh, 1'b0);
		chk(alarm, 1'b1);
	endtask : zero_interval
	initial begin
		boot_cases();
		rise_without_stop();
		start_interval();
		cap_hour();
		zero_interval();
		give_verdict();
	end
endmodule : tb_motor_restart_inhibit
